/* lf_sweep_seq.sv */
// LF frequency sweep sequencer with AXI4-Lite register access.
`timescale 1ns/1ns
module lf_sweep_seq (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic instrumentTriggerInput,
  output logic [31:0] lfFreq,
  output logic lfFreqUpdate,
  output logic freqSettled,
  output logic sweepActive,
  output logic otherSweepsOff,
  output logic listModeOff
);
  lf_sweep_pkg::seqReg_t q;
  lf_sweep_pkg::seqReg_t d;
  lf_sweep_pkg::stepReq_t stepReq;
  lf_sweep_pkg::stepRsp_t stepRsp;
  logic extEdge;
  logic wrNow;
  logic doExec;
  logic doReset;
  logic doMan;
  logic modeChg;
  logic stepDown;
  logic tick;
  logic [31:0] ctrlWord;
  logic [31:0] statusWord;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  // The outside source must deliver the edges that the external modes wait for.
  lf_trig_edge trigEdge (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .trigIn(instrumentTriggerInput),
    .slopeNeg(q.slopeNeg),
    .trigPulse(extEdge)
  );

  // The direction of the next step turns at the top only with triangle shape.
  assign stepDown = q.dir | (q.endHit & q.triangle);
  assign stepReq = '{cur: q.cur, width: q.stepW, start: q.start, stop: q.stop,
                     logSp: q.logSp, down: stepDown};

  lf_step_calc stepCalc (
    .req(stepReq),
    .rsp(stepRsp)
  );

  assign wrNow = q.awv & q.wv & ~q.bvalid;
  assign doExec = wrNow && q.awAddr == lf_sweep_pkg::OFF_CMD && q.wStrb[0] &&
                  q.wData[lf_sweep_pkg::CMD_EXEC_BIT];
  assign doReset = wrNow && q.awAddr == lf_sweep_pkg::OFF_CMD && q.wStrb[0] &&
                   q.wData[lf_sweep_pkg::CMD_RESET_BIT];
  assign doMan = wrNow && q.awAddr == lf_sweep_pkg::OFF_FREQ && q.sweepEn;
  assign modeChg = wrNow && q.awAddr == lf_sweep_pkg::OFF_CTRL && q.wStrb[0] &&
                   q.wData[lf_sweep_pkg::CTRL_MODE_MSB:lf_sweep_pkg::CTRL_MODE_LSB] != q.mode &&
                   q.st != lf_sweep_pkg::ST_IDLE;
  assign tick = q.st == lf_sweep_pkg::ST_RUN &&
                ({1'b0, q.dwellCnt} + 33'h1 >= {1'b0, q.dwell});
  assign ctrlWord = {25'h0, q.slopeNeg, q.logSp, q.triangle, q.mode, q.sweepEn};
  assign statusWord = {25'h0, q.restartPend, q.endHit, q.dir, q.phase, q.st};

  always_comb begin
    logic startSweep;
    logic oneStep;
    logic [31:0] cw;
    startSweep = 1'b0;
    oneStep = 1'b0;
    cw = merge(ctrlWord, q.wData, q.wStrb);
    d = q;
    d.upd = 1'b0;
    if (s_axi_awvalid && !q.awv) begin
      d.awv = 1'b1;
      d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.wv) begin
      d.wv = 1'b1;
      d.wData = s_axi_wdata;
      d.wStrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = lf_sweep_pkg::RESP_OKAY;
      case (s_axi_araddr)
        lf_sweep_pkg::OFF_CTRL: d.rdata = ctrlWord;
        lf_sweep_pkg::OFF_START: d.rdata = q.start;
        lf_sweep_pkg::OFF_STOP: d.rdata = q.stop;
        lf_sweep_pkg::OFF_STEP: d.rdata = q.stepW;
        lf_sweep_pkg::OFF_DWELL: d.rdata = q.dwell;
        lf_sweep_pkg::OFF_FREQ: d.rdata = q.cur;
        lf_sweep_pkg::OFF_CMD: d.rdata = 32'h0;
        lf_sweep_pkg::OFF_STATUS: d.rdata = statusWord;
        default: begin
          d.rdata = 32'h0;
          d.rresp = lf_sweep_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (wrNow) begin
      d.awv = 1'b0;
      d.wv = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = lf_sweep_pkg::RESP_OKAY;
      case (q.awAddr)
        lf_sweep_pkg::OFF_CTRL: begin
          d.sweepEn = cw[lf_sweep_pkg::CTRL_EN_BIT];
          d.mode = lf_sweep_pkg::sweepMode_t'(
            cw[lf_sweep_pkg::CTRL_MODE_MSB:lf_sweep_pkg::CTRL_MODE_LSB]);
          d.triangle = cw[lf_sweep_pkg::CTRL_TRI_BIT];
          d.logSp = cw[lf_sweep_pkg::CTRL_LOG_BIT];
          d.slopeNeg = cw[lf_sweep_pkg::CTRL_SLOPE_BIT];
        end
        lf_sweep_pkg::OFF_START: d.start = merge(q.start, q.wData, q.wStrb);
        lf_sweep_pkg::OFF_STOP: d.stop = merge(q.stop, q.wData, q.wStrb);
        lf_sweep_pkg::OFF_STEP: d.stepW = merge(q.stepW, q.wData, q.wStrb);
        lf_sweep_pkg::OFF_DWELL: d.dwell = merge(q.dwell, q.wData, q.wStrb);
        lf_sweep_pkg::OFF_FREQ: begin
          if (!q.sweepEn) begin
            d.cur = merge(q.cur, q.wData, q.wStrb);
            d.upd = 1'b1;
          end
        end
        lf_sweep_pkg::OFF_CMD: ;
        default: d.bresp = lf_sweep_pkg::RESP_SLVERR;
      endcase
    end
    if (!q.sweepEn) begin
      d.st = lf_sweep_pkg::ST_IDLE;
      d.phase = 2'd0;
      d.restartPend = 1'b1;
    end else if (doReset) begin
      d.cur = q.start;
      d.dir = 1'b0;
      d.endHit = 1'b0;
      d.restartPend = 1'b0;
      d.st = lf_sweep_pkg::ST_IDLE;
      d.phase = 2'd0;
      d.upd = 1'b1;
    end else if (modeChg) begin
      d.st = lf_sweep_pkg::ST_IDLE;
      d.phase = 2'd0;
      d.restartPend = 1'b1;
    end else begin
      case (q.mode)
        lf_sweep_pkg::MODE_AUTO: startSweep = q.st != lf_sweep_pkg::ST_RUN;
        lf_sweep_pkg::MODE_SINGLE: startSweep = q.st != lf_sweep_pkg::ST_RUN && doExec;
        lf_sweep_pkg::MODE_EXT_SINGLE: startSweep = q.st != lf_sweep_pkg::ST_RUN && extEdge;
        lf_sweep_pkg::MODE_STEP: oneStep = doMan;
        lf_sweep_pkg::MODE_EXT_STEP: oneStep = extEdge;
        lf_sweep_pkg::MODE_EXT_SS: begin
          if (extEdge) begin
            if (q.phase == 2'd1) begin
              d.st = lf_sweep_pkg::ST_HOLD;
              d.phase = 2'd2;
            end else begin
              startSweep = 1'b1;
              d.phase = 2'd1;
            end
          end
        end
        default: ;
      endcase
      if (startSweep) begin
        d.cur = q.start;
        d.dir = 1'b0;
        d.endHit = 1'b0;
        d.restartPend = 1'b0;
        d.st = lf_sweep_pkg::ST_RUN;
        d.upd = 1'b1;
      // A freeze that meets a dwell expiry must not take that step as well.
      end else if (oneStep || (tick && d.st == lf_sweep_pkg::ST_RUN)) begin
        if (q.restartPend || (q.endHit && (!q.triangle || q.dir))) begin
          d.endHit = 1'b0;
          d.dir = 1'b0;
          d.restartPend = 1'b0;
          if (tick && (q.mode == lf_sweep_pkg::MODE_SINGLE ||
                       q.mode == lf_sweep_pkg::MODE_EXT_SINGLE)) begin
            d.st = lf_sweep_pkg::ST_IDLE;
          end else begin
            d.cur = q.start;
            d.upd = 1'b1;
          end
        end else begin
          d.cur = stepRsp.nxt;
          d.dir = stepDown;
          d.endHit = stepRsp.atEnd;
          d.upd = 1'b1;
        end
      end
    end
    // Restart the dwell count on every new frequency so settling is measured per step.
    if (d.upd) begin
      d.dwellCnt = 32'h0;
    end else if (q.dwellCnt != 32'hffff_ffff) begin
      d.dwellCnt = q.dwellCnt + 32'h1;
    end
    d.settled = d.dwellCnt >= lf_sweep_pkg::SETTLE_CYC;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= lf_sweep_pkg::SEQ_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = ~q.awv;
  assign s_axi_wready = ~q.wv;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  // One frequency bus serves every modulation that takes the internal generator.
  assign lfFreq = q.cur;
  assign lfFreqUpdate = q.upd;
  assign freqSettled = q.settled;
  assign sweepActive = q.st == lf_sweep_pkg::ST_RUN;
  assign otherSweepsOff = q.sweepEn;
  assign listModeOff = q.sweepEn;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  property p_sweepOff;
    q.sweepEn |-> otherSweepsOff && listModeOff;
  endproperty
  a_sweepOff: assert property (p_sweepOff) else $error("Other sweeps not forced off.");

  property p_modeHalt;
    (q.sweepEn && modeChg && !doReset) |=> q.st == lf_sweep_pkg::ST_IDLE && q.restartPend;
  endproperty
  a_modeHalt: assert property (p_modeHalt) else $error("Mode change did not halt.");

  property p_autoRuns;
    (q.sweepEn && q.mode == lf_sweep_pkg::MODE_AUTO && q.st == lf_sweep_pkg::ST_IDLE &&
     !wrNow) |=> q.st == lf_sweep_pkg::ST_RUN && q.cur == $past(q.start);
  endproperty
  a_autoRuns: assert property (p_autoRuns) else $error("Auto sweep did not start.");

  property p_execIgnored;
    (q.sweepEn && q.mode != lf_sweep_pkg::MODE_SINGLE && q.mode != lf_sweep_pkg::MODE_AUTO &&
     q.st == lf_sweep_pkg::ST_IDLE && doExec && !extEdge) |=>
      q.st == lf_sweep_pkg::ST_IDLE && $stable(q.cur);
  endproperty
  a_execIgnored: assert property (p_execIgnored) else $error("Execute acted outside single.");

  property p_extStep;
    (q.sweepEn && q.mode == lf_sweep_pkg::MODE_EXT_STEP && extEdge && !wrNow) |=> q.upd;
  endproperty
  a_extStep: assert property (p_extStep) else $error("External edge gave no step.");

  property p_freeze;
    (q.sweepEn && q.mode == lf_sweep_pkg::MODE_EXT_SS && extEdge && q.phase == 2'd1 &&
     !wrNow) |=> q.st == lf_sweep_pkg::ST_HOLD && $stable(q.cur) ##1 $stable(q.cur) || wrNow;
  endproperty
  a_freeze: assert property (p_freeze) else $error("Second trigger did not freeze.");

  property p_reset;
    (q.sweepEn && doReset) |=> q.cur == $past(q.start) && q.st == lf_sweep_pkg::ST_IDLE;
  endproperty
  a_reset: assert property (p_reset) else $error("Reset did not load start.");

  sequence s_upStep;
    q.sweepEn && tick && !stepDown && !q.endHit && !q.restartPend && q.start <= q.stop;
  endsequence

  property p_clamp;
    s_upStep |=> q.cur <= $past(q.stop);
  endproperty
  a_clamp: assert property (p_clamp) else $error("Step passed stop frequency.");

  sequence s_runStep;
    q.sweepEn && q.st == lf_sweep_pkg::ST_RUN && q.upd && q.dwell == 32'h3 && !wrNow;
  endsequence

  property p_dwell;
    s_runStep ##1 !wrNow |-> !q.upd;
  endproperty
  a_dwell: assert property (p_dwell) else $error("Step shorter than dwell.");
endmodule

/* lf_sweep_pkg.sv */
// Package with register map, field layout, reset values, timing and types of the LF sweep.
package lf_sweep_pkg;
  localparam int FREQ_W = 32;
  localparam int ADDR_W = 8;
  localparam int LOG_FRAC_BITS = 16;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_START = 8'h04;
  localparam logic [7:0] OFF_STOP = 8'h08;
  localparam logic [7:0] OFF_STEP = 8'h0c;
  localparam logic [7:0] OFF_DWELL = 8'h10;
  localparam logic [7:0] OFF_FREQ = 8'h14;
  localparam logic [7:0] OFF_CMD = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;

  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MODE_MSB = 3;
  localparam int CTRL_TRI_BIT = 4;
  localparam int CTRL_LOG_BIT = 5;
  localparam int CTRL_SLOPE_BIT = 6;
  localparam int CMD_EXEC_BIT = 0;
  localparam int CMD_RESET_BIT = 1;

  localparam logic [31:0] START_RST = 32'h0000_0064;
  localparam logic [31:0] STOP_RST = 32'h0000_2710;
  localparam logic [31:0] STEP_RST = 32'h0000_0064;
  localparam logic [31:0] DWELL_RST = 32'h0001_e848;

  localparam int CLK_PERIOD_NS = 8;
  localparam int SETTLE_NS = 1000;
  localparam logic [31:0] SETTLE_CYC = 32'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    MODE_AUTO = 3'b000,
    MODE_SINGLE = 3'b001,
    MODE_STEP = 3'b010,
    MODE_EXT_SINGLE = 3'b011,
    MODE_EXT_STEP = 3'b100,
    MODE_EXT_SS = 3'b101
  } sweepMode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } seqState_t;

  typedef struct packed {
    logic [FREQ_W-1:0] cur;
    logic [FREQ_W-1:0] width;
    logic [FREQ_W-1:0] start;
    logic [FREQ_W-1:0] stop;
    logic logSp;
    logic down;
  } stepReq_t;

  typedef struct packed {
    logic [FREQ_W-1:0] nxt;
    logic atEnd;
  } stepRsp_t;

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic pulse;
  } trigReg_t;

  typedef struct packed {
    logic sweepEn;
    sweepMode_t mode;
    logic triangle;
    logic logSp;
    logic slopeNeg;
    logic [31:0] start;
    logic [31:0] stop;
    logic [31:0] stepW;
    logic [31:0] dwell;
    logic [31:0] cur;
    logic [31:0] dwellCnt;
    logic dir;
    logic endHit;
    logic restartPend;
    logic upd;
    logic settled;
    seqState_t st;
    logic [1:0] phase;
    logic awv;
    logic [ADDR_W-1:0] awAddr;
    logic wv;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } seqReg_t;

  localparam seqReg_t SEQ_RST = '{start: START_RST, stop: STOP_RST, stepW: STEP_RST,
    dwell: DWELL_RST, restartPend: 1'b1, mode: MODE_AUTO, st: ST_IDLE, default: '0};
endpackage

/* lf_trig_edge.sv */
// Synchroniser and slope-selectable edge detector for the instrument trigger input.
`timescale 1ns/1ns
module lf_trig_edge (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic trigIn,
  input wire logic slopeNeg,
  output logic trigPulse
);
  lf_sweep_pkg::trigReg_t q;
  lf_sweep_pkg::trigReg_t d;

  always_comb begin
    d = q;
    d.meta = trigIn;
    d.sync = q.meta;
    d.prev = q.sync;
    d.pulse = slopeNeg ? (q.prev & ~q.sync) : (~q.prev & q.sync);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign trigPulse = q.pulse;

  property p_onePulse;
    @(posedge core_clk) disable iff (sys_rst) q.pulse |=> !q.pulse;
  endproperty
  a_onePulse: assert property (p_onePulse) else $error("Trigger pulse lasted two cycles.");

  property p_slope;
    @(posedge core_clk) disable iff (sys_rst)
      (!slopeNeg && !q.prev && q.sync) |=> q.pulse;
  endproperty
  a_slope: assert property (p_slope) else $error("Rising edge not detected.");
endmodule

/* lf_step_calc.sv */
// Next-step frequency calculation for linear and logarithmic spacing with end clamping.
`timescale 1ns/1ns
module lf_step_calc (
  input wire lf_sweep_pkg::stepReq_t req,
  output lf_sweep_pkg::stepRsp_t rsp
);
  logic [63:0] prod;
  logic [31:0] inc;
  logic [32:0] sum;
  logic [32:0] floorSum;

  always_comb begin
    prod = req.cur * req.width;
    inc = req.logSp ? prod[lf_sweep_pkg::LOG_FRAC_BITS +: 32] : req.width;
    sum = {1'b0, req.cur} + {1'b0, inc};
    floorSum = {1'b0, req.start} + {1'b0, inc};
    rsp.nxt = req.cur;
    rsp.atEnd = 1'b0;
    if (!req.down) begin
      if (sum >= {1'b0, req.stop}) begin
        rsp.nxt = req.stop;
        rsp.atEnd = 1'b1;
      end else begin
        rsp.nxt = sum[31:0];
      end
    end else if ({1'b0, req.cur} <= floorSum) begin
      rsp.nxt = req.start;
      rsp.atEnd = 1'b1;
    end else begin
      rsp.nxt = req.cur - inc;
    end
  end
endmodule

/* lf_trig_source.sv */
// Model of the outside source that drives the instrument trigger input.
`timescale 1ns/1ns
module lf_trig_source (
  input wire logic core_clk,
  output logic trigLevel
);
  // The level starts low so that the first rise is a clean edge.
  initial begin
    trigLevel = 1'b0;
  end
  // Each level change is made after a clock edge and held for at least two edges.
  task automatic drive(input logic level, input int holdCycles);
    @(posedge core_clk);
    trigLevel <= level;
    repeat (holdCycles) @(posedge core_clk);
  endtask
endmodule

/* tb_lf_frequency_sweep_sequencer.sv */
// Self-checking testbench for the LF frequency sweep sequencer.
`timescale 1ns/1ns
module tb_lf_frequency_sweep_sequencer;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic trigLevel;
  logic [31:0] lfFreq;
  logic lfFreqUpdate;
  logic freqSettled;
  logic sweepActive;
  logic otherSweepsOff;
  logic listModeOff;
  int mismatches = 0;
  int checksDone = 0;
  int cyc = 0;
  int lastCyc = 0;
  logic [31:0] seen[$];
  int gaps[$];
  logic [1:0] resp;
  logic [31:0] rdv;

  lf_sweep_seq dut (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .instrumentTriggerInput(trigLevel), .lfFreq(lfFreq),
    .lfFreqUpdate(lfFreqUpdate), .freqSettled(freqSettled), .sweepActive(sweepActive),
    .otherSweepsOff(otherSweepsOff), .listModeOff(listModeOff));

  lf_trig_source trigSrc (.core_clk(core_clk), .trigLevel(trigLevel));

  always #4 core_clk = ~core_clk;

  always @(posedge core_clk) cyc <= cyc + 1;

  // Updates are logged on the falling edge, where the registered outputs have settled.
  always @(negedge core_clk) begin
    if (lfFreqUpdate === 1'b1) begin
      seen.push_back(lfFreq);
      gaps.push_back(cyc - lastCyc);
      lastCyc = cyc;
    end
  end

  task automatic end_of_test();
    if (mismatches == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ga;
    logic gw;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge core_clk);
      if (!ga && s_axi_awready === 1'b1) begin
        ga = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!gw && s_axi_wready === 1'b1) begin
        gw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [31:0] ctl(input lf_sweep_pkg::sweepMode_t m, input logic [2:0] f);
    ctl = {25'h0, f, m, 1'b1};
  endfunction

  // The sweep is switched off first, so every scenario starts from a known idle state.
  task automatic setup(input logic [31:0] st, input logic [31:0] sp, input logic [31:0] sw,
      input logic [31:0] c);
    wr(lf_sweep_pkg::OFF_CTRL, 32'h0, resp);
    wr(lf_sweep_pkg::OFF_FREQ, 32'h7, resp);
    wr(lf_sweep_pkg::OFF_START, st, resp);
    wr(lf_sweep_pkg::OFF_STOP, sp, resp);
    wr(lf_sweep_pkg::OFF_STEP, sw, resp);
    wr(lf_sweep_pkg::OFF_DWELL, 32'h3, resp);
    seen.delete();
    gaps.delete();
    wr(lf_sweep_pkg::OFF_CTRL, c, resp);
  endtask

  task automatic waitSeen(input int n);
    while (seen.size() < n) @(posedge core_clk);
  endtask

  task automatic checkSeen(input logic [31:0] exp[$]);
    check(32'(seen.size() >= exp.size()), 32'h1);
    for (int i = 0; i < exp.size() && i < seen.size(); i++) begin
      check(seen[i], exp[i]);
      if (i > 0) begin
        check(32'(gaps[i]), 32'h3);
      end
    end
  endtask

  task automatic stepSeq(input logic [31:0] exp[$]);
    foreach (exp[i]) begin
      wr(lf_sweep_pkg::OFF_FREQ, 32'h3039, resp);
      check(lfFreq, exp[i]);
    end
  endtask

  // The span covers all scenarios with a wide margin; a hang ends the run as a failure.
  initial begin
    repeat (8000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(lf_sweep_pkg::OFF_CTRL, rdv, resp);
    check(rdv, 32'h0);
    rd(lf_sweep_pkg::OFF_START, rdv, resp);
    check(rdv, lf_sweep_pkg::START_RST);
    rd(lf_sweep_pkg::OFF_STOP, rdv, resp);
    check(rdv, lf_sweep_pkg::STOP_RST);
    rd(lf_sweep_pkg::OFF_STEP, rdv, resp);
    check(rdv, lf_sweep_pkg::STEP_RST);
    rd(lf_sweep_pkg::OFF_DWELL, rdv, resp);
    check(rdv, lf_sweep_pkg::DWELL_RST);
    rd(8'h20, rdv, resp);
    check(rdv, 32'h0);
    check(32'(resp), 32'(lf_sweep_pkg::RESP_SLVERR));
    wr(8'h24, 32'h1, resp);
    check(32'(resp), 32'(lf_sweep_pkg::RESP_SLVERR));
    check(32'(otherSweepsOff), 32'h0);
    wr(lf_sweep_pkg::OFF_FREQ, 32'h1f4, resp);
    check(lfFreq, 32'h1f4);
    check(32'(freqSettled), 32'h0);
    repeat (130) @(posedge core_clk);
    check(32'(freqSettled), 32'h1);
    setup(32'h3e8, 32'h4e2, 32'h64, ctl(lf_sweep_pkg::MODE_STEP, 3'b000));
    check(32'(otherSweepsOff), 32'h1);
    check(32'(listModeOff), 32'h1);
    wr(lf_sweep_pkg::OFF_CMD, 32'h1, resp);
    check(lfFreq, 32'h7);
    stepSeq('{32'h3e8, 32'h44c, 32'h4b0, 32'h4e2, 32'h3e8});
    // Half of the current value per step keeps every expected frequency an exact integer.
    setup(32'h3e8, 32'hbb8, 32'h8000, ctl(lf_sweep_pkg::MODE_STEP, 3'b010));
    stepSeq('{32'h3e8, 32'h5dc, 32'h8ca, 32'hbb8, 32'h3e8});
    setup(32'h3e8, 32'h4e2, 32'h64, ctl(lf_sweep_pkg::MODE_EXT_STEP, 3'b000));
    trigSrc.drive(1'b1, 6);
    check(lfFreq, 32'h3e8);
    trigSrc.drive(1'b0, 6);
    check(lfFreq, 32'h3e8);
    trigSrc.drive(1'b1, 6);
    check(lfFreq, 32'h44c);
    wr(lf_sweep_pkg::OFF_CTRL, ctl(lf_sweep_pkg::MODE_EXT_STEP, 3'b100), resp);
    trigSrc.drive(1'b0, 6);
    check(lfFreq, 32'h4b0);
    trigSrc.drive(1'b1, 6);
    check(lfFreq, 32'h4b0);
    trigSrc.drive(1'b0, 3);
    setup(32'h3e8, 32'h4b0, 32'h64, ctl(lf_sweep_pkg::MODE_AUTO, 3'b000));
    waitSeen(7);
    checkSeen('{32'h3e8, 32'h44c, 32'h4b0, 32'h3e8, 32'h44c, 32'h4b0, 32'h3e8});
    while (lfFreq !== 32'h44c) @(posedge core_clk);
    wr(lf_sweep_pkg::OFF_CTRL, ctl(lf_sweep_pkg::MODE_EXT_SINGLE, 3'b000), resp);
    seen.delete();
    gaps.delete();
    repeat (20) @(posedge core_clk);
    check(32'(seen.size()), 32'h0);
    check(32'(sweepActive), 32'h0);
    trigSrc.drive(1'b1, 6);
    waitSeen(3);
    checkSeen('{32'h3e8, 32'h44c, 32'h4b0});
    repeat (20) @(posedge core_clk);
    check(32'(seen.size()), 32'h3);
    trigSrc.drive(1'b0, 3);
    wr(lf_sweep_pkg::OFF_CMD, 32'h2, resp);
    check(lfFreq, 32'h3e8);
    setup(32'h3e8, 32'h4b0, 32'h64, ctl(lf_sweep_pkg::MODE_SINGLE, 3'b000));
    repeat (20) @(posedge core_clk);
    check(32'(seen.size()), 32'h0);
    wr(lf_sweep_pkg::OFF_CMD, 32'h1, resp);
    waitSeen(3);
    checkSeen('{32'h3e8, 32'h44c, 32'h4b0});
    repeat (20) @(posedge core_clk);
    check(32'(seen.size()), 32'h3);
    check(lfFreq, 32'h4b0);
    setup(32'h3e8, 32'h4b0, 32'h64, ctl(lf_sweep_pkg::MODE_AUTO, 3'b001));
    waitSeen(5);
    checkSeen('{32'h3e8, 32'h44c, 32'h4b0, 32'h44c, 32'h3e8});
    setup(32'h3e8, 32'h76c, 32'h64, ctl(lf_sweep_pkg::MODE_EXT_SS, 3'b000));
    trigSrc.drive(1'b1, 6);
    trigSrc.drive(1'b0, 3);
    waitSeen(3);
    check(seen[0], 32'h3e8);
    trigSrc.drive(1'b1, 6);
    seen.delete();
    rdv = lfFreq;
    repeat (20) @(posedge core_clk);
    check(32'(seen.size()), 32'h0);
    check(lfFreq, rdv);
    check(32'(sweepActive), 32'h0);
    trigSrc.drive(1'b0, 3);
    trigSrc.drive(1'b1, 6);
    waitSeen(1);
    check(seen[0], 32'h3e8);
    check(32'(sweepActive), 32'h1);
    end_of_test();
  end
endmodule
